// ===== rdss_pkg.sv
package rdss_pkg;
  // Serial control word layout
  localparam int CTRL_W        = 6;
  localparam int STROBE_LSB    = 0;
  localparam int STROBE_W      = 5;
  localparam int SIGN_BIT      = 4;
  localparam int TEST_BIT      = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // Sequencing counts
  localparam logic [1:0] FREEZE_EDGES   = 2'h2;
  localparam logic [1:0] RESTART_EDGES  = 2'h2;
  localparam logic [2:0] ABORT_MAX_REF  = 3'h4;
  localparam logic [1:0] REST_REF_EDGES = 2'h1;
  // Preamble run lengths, typical values
  localparam logic [5:0] RUN_1T = 6'h22;
  localparam logic [5:0] RUN_2T = 6'h21;
  localparam logic [5:0] RUN_3T = 6'h20;
  localparam logic [5:0] RUN_4T = 6'h10;
  // Strobe step in thousandths of a reference period
  localparam int STEP_PERMIL = 18;

  typedef enum logic [2:0] {
    SEQ_REF    = 3'b000,
    SEQ_FREEZE = 3'b001,
    SEQ_WAIT   = 3'b011,
    SEQ_VCO    = 3'b010,
    SEQ_ABORT  = 3'b110,
    SEQ_REST   = 3'b111
  } rdss_seq_e;

  typedef struct packed {
    logic       test_mode;
    logic       late;
    logic [3:0] magnitude;
  } rdss_ctrl_s;
endpackage : rdss_pkg

// ===== rdss_shift_ctrl.sv
`timescale 1ns/1ps
module rdss_shift_ctrl
  import rdss_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Serial load pins
  input  wire logic         load_en_n_i,
  input  wire logic         shift_clk_i,
  input  wire logic         shift_in_i,
  // Parallel word
  output rdss_pkg::rdss_ctrl_s word_o
);
  logic [CTRL_W-1:0] sreg_q;
  logic              sclk_q;
  wire               shift_fall = sclk_q & ~shift_clk_i & ~load_en_n_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sreg_q <= CTRL_RESET;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= shift_clk_i;
      // Clock and data are ignored while the enable is high
      if (shift_fall) sreg_q <= {sreg_q[CTRL_W-2:0], shift_in_i};
    end
  end

  assign word_o = rdss_ctrl_s'(sreg_q);
endmodule : rdss_shift_ctrl

// ===== rdss_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - After a read gate rise the oscillator freezes on the 2nd falling edge of sync clock.
// - A frozen read lock restarts on the 2nd rising edge of read data after the freeze.
// - On read gate release the reference restart begins within 4 reference cycles.
// - Sync clock is held high for a rest period before each source switch.
// - With the 1T pattern the found flag rises after a run of 34 read data pulses.
// - With the 2T pattern the found flag rises after a run of 33 read data pulses.
// - With the 3T pattern the found flag rises after a run of 32 read data pulses.
// - With the 4T pattern the found flag rises after a run of 16 read data pulses.
// - The found flag is set on a falling edge of sync clock ending the run.
// - An all zero word gives nominal timing and minus 15 gives the earliest window.
// - With read gate low, outside the abort and rest, the reference clock passes to sync clock through one register, a clock cycle later.
// - Both edges of resynchronized data launch on sync clock falling edges.
// - Control bits shift on the falling shift clock while enable is low, else ignored.
// - Bits 0 to 4 form the strobe word and bit 5 the test mode.
// - Preamble search starts after the restart and the flag holds until read gate drops.
module rdss_sequencer
  import rdss_pkg::*;
#(
  parameter int VCO_DIV = 2
) (
  // Clock and reset
  input  wire logic             CLOCK_I,
  input  wire logic             RST_I,
  // Controller side
  input  wire logic             READ_GATE_I,
  input  wire logic [1:0]       PATTERN_SEL_I,
  input  wire logic             SHIFT_LOAD_EN_N_I,
  input  wire logic             SHIFT_CLK_I,
  input  wire logic             SHIFT_SERIAL_IN_I,
  // Drive side
  input  wire logic             REF_CLK_I,
  input  wire logic             ENCODED_READ_DATA_I,
  // Outputs
  output logic                  SYNC_CLK_O,
  output logic                  SYNC_DATA_O,
  output logic                  PREAMBLE_FOUND_O,
  output logic                  RESTART_BUSY_O,
  output logic signed [4:0]     WINDOW_STEP_O,
  output logic [9:0]            WINDOW_SHIFT_PERMIL_O,
  output logic                  TEST_MODE_O
);
  import rdss_pkg::*;

  rdss_ctrl_s ctrl;
  rdss_seq_e  st_q, st_d;
  logic       rg_q, ref_q, erd_q, sck_q;
  logic [1:0] edge_cnt_q;
  logic [2:0] ref_cnt_q;
  logic [7:0] vco_div_q;
  logic       vco_q;
  logic [5:0] run_q;
  logic [3:0] gap_q;
  logic       hit_q, data_pend_q;

  rdss_shift_ctrl u_ctrl (
    .clk_i       (CLOCK_I),
    .rst_i       (RST_I),
    .load_en_n_i (SHIFT_LOAD_EN_N_I),
    .shift_clk_i (SHIFT_CLK_I),
    .shift_in_i  (SHIFT_SERIAL_IN_I),
    .word_o      (ctrl)
  );

  wire rg_edge   = READ_GATE_I ^ rg_q;
  wire erd_rise  = ENCODED_READ_DATA_I & ~erd_q;
  wire ref_rise  = REF_CLK_I & ~ref_q;
  wire vco_tick  = (vco_div_q == 8'(VCO_DIV - 1));
  // State decode
  wire in_ref    = (st_q == SEQ_REF);
  wire in_freeze = (st_q == SEQ_FREEZE);
  wire in_wait   = (st_q == SEQ_WAIT);
  wire in_vco    = (st_q == SEQ_VCO);
  // Source mux: the reference keeps running through the freeze, which is
  // itself timed by sync clock falls; held high while resting
  wire sck_src   = in_vco ? vco_q :
                   (in_ref || in_freeze) ? REF_CLK_I : 1'b1;
  wire sck_fall  = sck_q & ~sck_src;
  wire [5:0] run_need = (PATTERN_SEL_I == 2'h0) ? RUN_1T :
                        (PATTERN_SEL_I == 2'h1) ? RUN_2T :
                        (PATTERN_SEL_I == 2'h2) ? RUN_3T : RUN_4T;
  // Expected spacing in oscillator ticks is pattern select plus one
  wire [3:0] gap_need = {2'h0, PATTERN_SEL_I} + 4'h1;
  wire       gap_ok   = (gap_q == gap_need);
  // One spacing tick per oscillator period; saturates so a long gap never wraps to a match
  wire       gap_tick = vco_tick && vco_q && (gap_q != 4'hf);
  wire       run_done = (run_q >= run_need);

  always_comb begin
    st_d = st_q;
    case (st_q)
      SEQ_REF: begin
        if (rg_edge && READ_GATE_I) st_d = SEQ_FREEZE;
      end
      SEQ_FREEZE: begin
        if (!READ_GATE_I) st_d = SEQ_ABORT;
        else if (sck_fall && edge_cnt_q == FREEZE_EDGES - 2'h1) st_d = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (!READ_GATE_I) st_d = SEQ_ABORT;
        else if (erd_rise && edge_cnt_q == RESTART_EDGES - 2'h1) st_d = SEQ_VCO;
      end
      SEQ_VCO: begin
        if (!READ_GATE_I) st_d = SEQ_ABORT;
      end
      SEQ_ABORT: begin
        if (ref_rise && ref_cnt_q == ABORT_MAX_REF - 3'h2) st_d = SEQ_REST;
      end
      SEQ_REST: begin
        // A read gate raised during the return would otherwise be missed
        if (ref_rise && ref_cnt_q == 3'(REST_REF_EDGES))
          st_d = READ_GATE_I ? SEQ_FREEZE : SEQ_REF;
      end
      default: st_d = SEQ_REF;
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= SEQ_REF;
      rg_q <= 1'b0;
      ref_q <= 1'b0;
      erd_q <= 1'b0;
      sck_q <= 1'b1;
    end else begin
      st_q <= st_d;
      rg_q <= READ_GATE_I;
      ref_q <= REF_CLK_I;
      erd_q <= ENCODED_READ_DATA_I;
      sck_q <= sck_src;
    end
  end

  // Edge and cycle counters restart on each state change
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      edge_cnt_q <= 2'h0;
      ref_cnt_q <= 3'h0;
    end else if (st_d != st_q) begin
      edge_cnt_q <= 2'h0;
      ref_cnt_q <= 3'h0;
    end else begin
      if ((in_freeze && sck_fall) || (in_wait && erd_rise))
        edge_cnt_q <= edge_cnt_q + 2'h1;
      if (ref_rise) ref_cnt_q <= ref_cnt_q + 3'h1;
    end
  end

  // Oscillator model: held high while frozen, phase zeroed at restart
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      vco_div_q <= 8'h00;
      vco_q <= 1'b1;
    end else if (!in_vco) begin
      vco_div_q <= 8'h00;
      vco_q <= 1'b1;
    end else if (vco_tick) begin
      vco_div_q <= 8'h00;
      vco_q <= ~vco_q;
    end else begin
      vco_div_q <= vco_div_q + 8'h01;
    end
  end

  // Preamble detector; a mis-spaced pulse restarts the run
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      run_q <= 6'h00;
      gap_q <= 4'h0;
      hit_q <= 1'b0;
    end else if (!in_vco) begin
      run_q <= 6'h00;
      gap_q <= 4'h0;
      hit_q <= hit_q & READ_GATE_I;
    end else begin
      if (erd_rise) begin
        gap_q <= 4'h0;
        if (run_q == 6'h00 || gap_ok) run_q <= run_q + 6'h01;
        else run_q <= 6'h01;
      end else if (gap_tick) begin
        gap_q <= gap_q + 4'h1;
      end
      if (run_done) hit_q <= 1'b1;
    end
  end

  // Output next values; flag and data follow sync clock falling edges
  wire              busy_d   = !in_ref && !in_vco;
  wire              data_d   = sck_fall ? data_pend_q : SYNC_DATA_O;
  wire              found_d  = READ_GATE_I && (PREAMBLE_FOUND_O || (sck_fall && hit_q));
  wire signed [4:0] mag_s    = $signed({1'b0, ctrl.magnitude});
  // Bit 4 set gives a negative, earlier window
  wire signed [4:0] step_d   = ctrl.late ? -mag_s : mag_s;
  wire [9:0]        permil_d = 10'(ctrl.magnitude * STEP_PERMIL);

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      SYNC_CLK_O <= 1'b1;
      SYNC_DATA_O <= 1'b0;
      data_pend_q <= 1'b0;
      PREAMBLE_FOUND_O <= 1'b0;
      RESTART_BUSY_O <= 1'b0;
    end else begin
      SYNC_CLK_O <= sck_src;
      if (erd_rise) data_pend_q <= ~data_pend_q;
      SYNC_DATA_O <= data_d;
      PREAMBLE_FOUND_O <= found_d;
      RESTART_BUSY_O <= busy_d;
    end
  end

  // Control word outputs; a half-loaded word shows until the last bit lands
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      WINDOW_STEP_O <= 5'sh00;
      WINDOW_SHIFT_PERMIL_O <= 10'h000;
      TEST_MODE_O <= 1'b0;
    end else begin
      WINDOW_STEP_O <= step_d;
      WINDOW_SHIFT_PERMIL_O <= permil_d;
      TEST_MODE_O <= ctrl.test_mode;
    end
  end
endmodule : rdss_sequencer

// ===== rdss_drive_model.sv
`timescale 1ns/1ps
module rdss_drive_model (
  // Clock
  input  wire logic clk_i,
  // Drive side
  output logic      ref_clk_o,
  output logic      read_data_o
);
  logic div_q = 1'b0;
  initial ref_clk_o = 1'b0;
  initial read_data_o = 1'b0;
  // Reference runs free at a quarter of the system clock
  always @(posedge clk_i) begin
    div_q <= ~div_q;
    if (div_q) ref_clk_o <= ~ref_clk_o;
  end
  // One pulse per gap cycles; the line is low between pulses
  task automatic pulse(input int gap);
    @(posedge clk_i) #1 read_data_o = 1'b1;
    @(posedge clk_i) #1 read_data_o = 1'b0;
    repeat (gap - 2) @(posedge clk_i);
    // Return off the edge so callers read settled outputs
    #1;
  endtask : pulse
endmodule : rdss_drive_model

// ===== rdss_sequencer_checker.sv
`timescale 1ns/1ps
module rdss_sequencer_checker (
  // Watched ports
  input wire logic              CLOCK_I,
  input wire logic              RST_I,
  input wire logic              READ_GATE_I,
  input wire logic              SHIFT_LOAD_EN_N_I,
  input wire logic              REF_CLK_I,
  input wire logic              SYNC_CLK_O,
  input wire logic              SYNC_DATA_O,
  input wire logic              PREAMBLE_FOUND_O,
  input wire logic              RESTART_BUSY_O,
  input wire logic signed [4:0] WINDOW_STEP_O,
  input wire logic [9:0]        WINDOW_SHIFT_PERMIL_O,
  input wire logic              TEST_MODE_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  wire idle = !READ_GATE_I && !RESTART_BUSY_O;
  ref_pass_a: assert property (idle && $past(idle) && $past(idle, 2) && !$past(RST_I)
    |-> SYNC_CLK_O == $past(REF_CLK_I)) else $error("sync clock not following ref");
  flag_hold_a: assert property (PREAMBLE_FOUND_O && READ_GATE_I |=> PREAMBLE_FOUND_O)
    else $error("found flag dropped");
  flag_clear_a: assert property (!READ_GATE_I [*3] |-> !PREAMBLE_FOUND_O)
    else $error("found flag outside read");
  flag_edge_a: assert property ($rose(PREAMBLE_FOUND_O)
    |-> !SYNC_CLK_O && READ_GATE_I && !RESTART_BUSY_O) else $error("flag edge misplaced");
  data_edge_a: assert property ($changed(SYNC_DATA_O) |-> !SYNC_CLK_O)
    else $error("data moved off clock fall");
  step_scale_a: assert property ($stable(WINDOW_STEP_O) |-> WINDOW_SHIFT_PERMIL_O ==
    10'(18 * (WINDOW_STEP_O < 0 ? -WINDOW_STEP_O : WINDOW_STEP_O))) else $error("step scale");
  busy_start_a: assert property ($rose(READ_GATE_I) |-> ##[0:2] RESTART_BUSY_O)
    else $error("no restart on read gate");
  ref_return_a: assert property ($fell(READ_GATE_I) |-> ##[1:30] idle ##1 idle)
    else $error("slow return to ref");
  load_ignore_a: assert property (SHIFT_LOAD_EN_N_I [*4] |=> $stable(WINDOW_STEP_O)
    && $stable(TEST_MODE_O)) else $error("word changed while disabled");
  cover property ($rose(PREAMBLE_FOUND_O));
  cover property ($fell(RESTART_BUSY_O) && READ_GATE_I);
  cover property (TEST_MODE_O && WINDOW_STEP_O < 0);
endmodule : rdss_sequencer_checker

bind rdss_sequencer rdss_sequencer_checker chk (.CLOCK_I, .RST_I, .READ_GATE_I,
  .SHIFT_LOAD_EN_N_I, .REF_CLK_I, .SYNC_CLK_O, .SYNC_DATA_O, .PREAMBLE_FOUND_O,
  .RESTART_BUSY_O, .WINDOW_STEP_O, .WINDOW_SHIFT_PERMIL_O, .TEST_MODE_O);

// ===== rdss_sequencer_bench.sv
`timescale 1ns/1ps
module rdss_sequencer_bench;
  logic clk = 1'b0, rst = 1'b1, rg = 1'b0, en_n = 1'b1, sclk = 1'b0, sdat = 1'b0;
  logic [1:0] sel = 2'h0;
  wire ref_clk, rdata;
  logic sync_clk, sync_data, found, busy, test;
  logic signed [4:0] step;
  logic [9:0] permil;
  logic [3:0] m;
  logic [4:0] es;
  logic [5:0] words [4] = '{6'h00, 6'h1f, 6'h0f, 6'h35};
  int typs [4] = '{34, 33, 32, 16};
  int fail_count = 0, checks = 0, cyc = 0, n, g, pulses = 0;
  bit brk = 1'b0;
  rdss_drive_model drv (.clk_i(clk), .ref_clk_o(ref_clk), .read_data_o(rdata));
  rdss_sequencer dut (.CLOCK_I(clk), .RST_I(rst), .READ_GATE_I(rg), .PATTERN_SEL_I(sel),
    .SHIFT_LOAD_EN_N_I(en_n), .SHIFT_CLK_I(sclk), .SHIFT_SERIAL_IN_I(sdat),
    .REF_CLK_I(ref_clk), .ENCODED_READ_DATA_I(rdata), .SYNC_CLK_O(sync_clk),
    .SYNC_DATA_O(sync_data), .PREAMBLE_FOUND_O(found), .RESTART_BUSY_O(busy),
    .WINDOW_STEP_O(step), .WINDOW_SHIFT_PERMIL_O(permil), .TEST_MODE_O(test));
  initial forever #20 clk = ~clk;
  // Every read pulse toggles the resynchronized data once
  always @(posedge rdata) pulses++;
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // Whole test needs about 1600 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Six bits, first bit ends as bit 5, taken on the falling shift clock
  task automatic load(input logic [5:0] w, input logic en);
    en_n = ~en;
    for (int i = 5; i >= 0; i--) begin
      sdat = w[i];
      @(posedge clk) #1 sclk = 1'b1;
      @(posedge clk) #1 sclk = 1'b0;
      @(posedge clk) #1;
    end
    en_n = 1'b1;
    repeat (4) @(posedge clk) #1;
  endtask : load
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    foreach (words[k]) begin
      load(words[k], 1'b1);
      m = words[k][3:0];
      es = words[k][4] ? -{1'b0, m} : {1'b0, m};
      chk("step", {5'h00, es}, {5'h00, step});
      chk("permil", 10'(m * 18), permil);
      chk("test mode", {9'h000, words[k][5]}, {9'h000, test});
    end
    load(6'h2a, 1'b0);
    chk("ignored step", {5'h00, es}, {5'h00, step});
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      g = 4 * (s + 1);
      rg = 1'b1;
      repeat (24) @(posedge clk) #1;
      chk("busy frozen", 10'h001, {9'h000, busy});
      chk("sync rest", 10'h001, {9'h000, sync_clk});
      drv.pulse(g);
      drv.pulse(g);
      chk("busy after restart", 10'h000, {9'h000, busy});
      n = 0;
      while (found !== 1'b1 && n < 45) begin
        if (s == 3 && n == 8 && !brk) begin
          drv.pulse(g / 2);
          brk = 1'b1;
          n = 0;
        end
        drv.pulse(g);
        n++;
      end
      chk("run length", 10'(typs[s]),
        (n >= typs[s] - 1 && n <= typs[s] + 1) ? 10'(typs[s]) : 10'(n));
      rg = 1'b0;
      repeat (40) @(posedge clk) #1;
      chk("flag clear", 10'h000, {9'h000, found});
      chk("busy idle", 10'h000, {9'h000, busy});
      chk("sync data", {9'h000, pulses[0]}, {9'h000, sync_data});
    end
    stop_test();
  end
endmodule : rdss_sequencer_bench
